/* inc/pps_pkg.sv */
// Package: register map, reset values and steering tables for the port block
package pps_pkg;
    // Widths
    localparam int PPS_W = 8;
    localparam int PPS_NFN = 9;
    localparam int PPS_NPIN = 16;
    localparam int PPS_AW = 4;
    // Register offsets
    localparam logic [3:0] PPS_ADDR_A_DIR = 4'h0;
    localparam logic [3:0] PPS_ADDR_A_PIN = 4'h1;
    localparam logic [3:0] PPS_ADDR_A_LAT = 4'h2;
    localparam logic [3:0] PPS_ADDR_A_ANS = 4'h3;
    localparam logic [3:0] PPS_ADDR_B_DIR = 4'h4;
    localparam logic [3:0] PPS_ADDR_B_PIN = 4'h5;
    localparam logic [3:0] PPS_ADDR_B_LAT = 4'h6;
    localparam logic [3:0] PPS_ADDR_B_ANS = 4'h7;
    localparam logic [3:0] PPS_ADDR_SEL0 = 4'h8;
    localparam logic [3:0] PPS_ADDR_SEL1 = 4'h9;
    // Reset values
    localparam logic [7:0] PPS_RST_DIR = 8'hff;
    localparam logic [7:0] PPS_RST_LAT = 8'h00;
    localparam logic [7:0] PPS_RST_ANS = 8'hff;
    localparam logic [7:0] PPS_RST_SEL = 8'h00;
    // Implemented bit masks
    localparam logic [7:0] PPS_A_IN_ONLY = 8'h20;
    localparam logic [7:0] PPS_A_LAT_IMPL = 8'hdf;
    localparam logic [7:0] PPS_B_LAT_IMPL = 8'hff;
    localparam logic [7:0] PPS_A_ANS_IMPL = 8'h1f;
    localparam logic [7:0] PPS_B_ANS_IMPL = 8'hff;
    localparam logic [7:0] PPS_SEL1_IMPL = 8'h01;
    // Input-only pin index on port a
    localparam int PPS_A_IN_PIN = 5;
    // Function indices
    localparam int PPS_FN_RX = 0;
    localparam int PPS_FN_SPI_DOUT = 1;
    localparam int PPS_FN_SPI_SEL = 2;
    localparam int PPS_FN_PWM2_B = 3;
    localparam int PPS_FN_CAP2 = 4;
    localparam int PPS_FN_PWM1_D = 5;
    localparam int PPS_FN_PWM1_C = 6;
    localparam int PPS_FN_CAP1 = 7;
    localparam int PPS_FN_TX = 8;
    // Pin numbers: 0..7 port a, 8..15 port b; entries fn8 down to fn0
    localparam logic [8:0][3:0] PPS_DEF_PIN = {
        4'ha, 4'hb, 4'he, 4'hf, 4'he, 4'hf, 4'hd, 4'ha, 4'h9};
    localparam logic [8:0][3:0] PPS_ALT_PIN = {
        4'hd, 4'h8, 4'h7, 4'h6, 4'h7, 4'h6, 4'h5, 4'h6, 4'ha};
    // Peripheral drive bundle
    typedef struct packed {
        logic [8:0] out;
        logic [8:0] oe;
    } pps_fn_t;
    // One bit per pin, port a in the low byte
    typedef struct packed {
        logic [7:0] b;
        logic [7:0] a;
    } pps_pins_t;
endpackage : pps_pkg

/* core/pps_port.sv */
// Port a/b logic with alternate pin steering and register slave
`timescale 1ns/1ps
module pps_port
    import pps_pkg::*;
(
    input wire logic core_clk_in,             // System clock
    input wire logic nrst_in,                 // Async reset, low
    input wire logic [PPS_AW-1:0] reg_addr_in, // Register address
    input wire logic [7:0] reg_wdata_in,      // Write data
    input wire logic reg_wr_in,               // Write strobe
    input wire logic reg_rd_in,               // Read strobe
    output logic [7:0] reg_rdata_out,         // Read data, next cycle
    input wire pps_pins_t pin_in,             // Pin levels
    output pps_pins_t pin_out,                // Pin drive values
    output pps_pins_t pin_oe_out,             // Pin drive enables
    input wire pps_fn_t fn_drive_in,          // Peripheral overrides
    output logic [8:0] fn_level_out           // Level at function pin
);
    // Register state
    logic [7:0] dir_a_reg;       // Port a direction
    logic [7:0] dir_b_reg;       // Port b direction
    logic [7:0] lat_a_reg;       // Port a latch
    logic [7:0] lat_b_reg;       // Port b latch
    logic [7:0] ans_a_reg;       // Port a analog select
    logic [7:0] ans_b_reg;       // Port b analog select
    logic [7:0] sel0_reg;        // Pin select 0
    logic [7:0] sel1_reg;        // Pin select 1
    logic [7:0] rdata_reg;       // Read data
    // Synchroniser and output flops
    logic [15:0] sync1_reg;      // First stage
    logic [15:0] sync2_reg;      // Second stage
    logic [15:0] pout_reg;       // Pin value
    logic [15:0] poe_reg;        // Pin enable
    logic [8:0] fnl_reg;         // Function level

    // Next values
    logic [7:0] dir_a_next;
    logic [7:0] dir_b_next;
    logic [7:0] lat_a_next;
    logic [7:0] lat_b_next;
    logic [7:0] ans_a_next;
    logic [7:0] ans_b_next;
    logic [7:0] sel0_next;
    logic [7:0] sel1_next;
    logic [7:0] rdata_next;
    logic [15:0] pout_next;
    logic [15:0] poe_next;
    logic [8:0] fnl_next;

    // Decode wires
    wire logic hit_a_dir = reg_addr_in == PPS_ADDR_A_DIR;
    wire logic hit_a_pin = reg_addr_in == PPS_ADDR_A_PIN;
    wire logic hit_a_lat = reg_addr_in == PPS_ADDR_A_LAT;
    wire logic hit_a_ans = reg_addr_in == PPS_ADDR_A_ANS;
    wire logic hit_b_dir = reg_addr_in == PPS_ADDR_B_DIR;
    wire logic hit_b_pin = reg_addr_in == PPS_ADDR_B_PIN;
    wire logic hit_b_lat = reg_addr_in == PPS_ADDR_B_LAT;
    wire logic hit_b_ans = reg_addr_in == PPS_ADDR_B_ANS;
    wire logic hit_sel0 = reg_addr_in == PPS_ADDR_SEL0;
    wire logic hit_sel1 = reg_addr_in == PPS_ADDR_SEL1;

    // Digital input path
    logic [15:0] dig;            // Level after analog gate
    assign dig = sync2_reg & ~{ans_b_reg, ans_a_reg};

    // Write strobes; level and latch share one path
    // latch write same as level write
    wire logic wr_lat_a = reg_wr_in && (hit_a_pin || hit_a_lat);
    wire logic wr_lat_b = reg_wr_in && (hit_b_pin || hit_b_lat);
    wire logic wr_dir_a = reg_wr_in && hit_a_dir;
    wire logic wr_dir_b = reg_wr_in && hit_b_dir;

    // sampled pins merged with write data
    wire logic [7:0] mrg_a = (dig[7:0] & ~PPS_A_LAT_IMPL)
                           | (reg_wdata_in & PPS_A_LAT_IMPL);
    wire logic [7:0] mrg_b = (dig[15:8] & ~PPS_B_LAT_IMPL)
                           | (reg_wdata_in & PPS_B_LAT_IMPL);

    // Register next values
    assign lat_a_next = wr_lat_a ? mrg_a : lat_a_reg;
    assign lat_b_next = wr_lat_b ? mrg_b : lat_b_reg;
    // input-only direction bit held at one
    assign dir_a_next = wr_dir_a ? (reg_wdata_in | PPS_A_IN_ONLY) : dir_a_reg;
    assign dir_b_next = wr_dir_b ? reg_wdata_in : dir_b_reg;
    assign ans_a_next = (reg_wr_in && hit_a_ans) ?
                        (reg_wdata_in & PPS_A_ANS_IMPL) : ans_a_reg;
    assign ans_b_next = (reg_wr_in && hit_b_ans) ?
                        (reg_wdata_in & PPS_B_ANS_IMPL) : ans_b_reg;
    assign sel0_next = (reg_wr_in && hit_sel0) ? reg_wdata_in : sel0_reg;
    // only bit 0 of select 1 is kept
    assign sel1_next = (reg_wr_in && hit_sel1) ?
                       (reg_wdata_in & PPS_SEL1_IMPL) : sel1_reg;

    // Read mux; unmapped offsets read zero
    logic [7:0] rd_mux;
    assign rd_mux = hit_a_dir ? dir_a_reg :
                    hit_a_pin ? dig[7:0] :
                    hit_a_lat ? (lat_a_reg & PPS_A_LAT_IMPL) :
                    hit_a_ans ? ans_a_reg :
                    hit_b_dir ? dir_b_reg :
                    hit_b_pin ? dig[15:8] :
                    hit_b_lat ? (lat_b_reg & PPS_B_LAT_IMPL) :
                    hit_b_ans ? ans_b_reg :
                    hit_sel0 ? sel0_reg :
                    hit_sel1 ? sel1_reg : 8'h00;
    // Data valid only in the cycle after the strobe
    assign rdata_next = reg_rd_in ? rd_mux : 8'h00;

    // Per-function pin choice, one bit each
    logic [8:0] choice;
    logic [8:0][3:0] cur_pin;    // Pin now carrying each function
    // select 1 bit 0 uart transmit
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_ch
            assign choice[g] = sel0_reg[7-g];
        end
        for (g = 0; g < PPS_NFN; g++) begin : g_pin
            assign cur_pin[g] = choice[g] ? PPS_ALT_PIN[g] : PPS_DEF_PIN[g];
        end
    endgenerate
    assign choice[PPS_FN_TX] = sel1_reg[0];

    // Pin drive and function level steering
    always_comb begin
        // direction gates driver with latch value
        // analog select plays no part in pin drive
        pout_next = {lat_b_reg, lat_a_reg};
        poe_next = ~{dir_b_reg, dir_a_reg};
        fnl_next = 9'h000;
        for (int f = PPS_NFN - 1; f >= 0; f--) begin
            if (fn_drive_in.oe[f]) begin
                pout_next[cur_pin[f]] = fn_drive_in.out[f];
                poe_next[cur_pin[f]] = 1'b1;
            end
            fnl_next[f] = dig[cur_pin[f]];
        end
        poe_next[PPS_A_IN_PIN] = 1'b0;
    end

    // Pin synchroniser
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_reg <= 16'h0000;
            sync2_reg <= 16'h0000;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Port registers
    // eight-bit direction, latch per port
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dir_a_reg <= PPS_RST_DIR;
            dir_b_reg <= PPS_RST_DIR;
            lat_a_reg <= PPS_RST_LAT;
            lat_b_reg <= PPS_RST_LAT;
            ans_a_reg <= PPS_RST_ANS & PPS_A_ANS_IMPL;
            ans_b_reg <= PPS_RST_ANS & PPS_B_ANS_IMPL;
        end else begin
            dir_a_reg <= dir_a_next;
            dir_b_reg <= dir_b_next;
            lat_a_reg <= lat_a_next;
            lat_b_reg <= lat_b_next;
            ans_a_reg <= ans_a_next;
            ans_b_reg <= ans_b_next;
        end
    end

    // Selection registers
    // selections clear on reset
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sel0_reg <= PPS_RST_SEL;
            sel1_reg <= PPS_RST_SEL;
        end else begin
            sel0_reg <= sel0_next;
            sel1_reg <= sel1_next;
        end
    end

    // Output flops
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_reg <= 8'h00;
            pout_reg <= 16'h0000;
            poe_reg <= 16'h0000;
            fnl_reg <= 9'h000;
        end else begin
            rdata_reg <= rdata_next;
            pout_reg <= pout_next;
            poe_reg <= poe_next;
            fnl_reg <= fnl_next;
        end
    end

    // Outputs
    assign reg_rdata_out = rdata_reg;
    assign pin_out = pout_reg;
    assign pin_oe_out = poe_reg;
    assign fn_level_out = fnl_reg;

    // Checks
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);

    // Strobe sequences
    sequence s_rd(logic [3:0] a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    sequence s_wr(logic [3:0] a);
        reg_wr_in && reg_addr_in == a;
    endsequence

    a5_dir_a: assert property (s_rd(PPS_ADDR_A_DIR) |=> reg_rdata_out[5])
        else $error("input-only direction bit read zero");
    a5_oe_a: assert property (!pin_oe_out.a[5])
        else $error("input-only pin driven");
    lat_read_a: assert property (s_rd(PPS_ADDR_A_LAT) |=>
        reg_rdata_out == ($past(lat_a_reg) & PPS_A_LAT_IMPL))
        else $error("latch read mismatch");
    // pin level readback with analog gate
    pin_read_a: assert property (s_rd(PPS_ADDR_A_PIN) |=>
        reg_rdata_out == $past(sync2_reg[7:0] & ~ans_a_reg))
        else $error("pin level read mismatch");
    // merge on write through level address
    rmw_write_a: assert property (s_wr(PPS_ADDR_A_PIN) |=>
        lat_a_reg == $past(mrg_a))
        else $error("level write did not load latch");
    lat_write_a: assert property (s_wr(PPS_ADDR_A_LAT) |=>
        lat_a_reg == (($past(dig[7:0]) & ~PPS_A_LAT_IMPL)
                     | ($past(reg_wdata_in) & PPS_A_LAT_IMPL)))
        else $error("latch write differs");
    // pin a0 follows direction and latch
    drv_pin_a: assert property (1'b1 |=>
        pin_oe_out.a[0] == !$past(dir_a_reg[0])
        && pin_out.a[0] == $past(lat_a_reg[0]))
        else $error("pin a0 drive wrong");
    rx_steer_a: assert property (1'b1 |=>
        fn_level_out[PPS_FN_RX] == $past(sel0_reg[7] ? dig[10] : dig[9]))
        else $error("receive level from wrong pin");
    tx_steer_a: assert property (fn_drive_in.oe[PPS_FN_TX] && sel1_reg[0]
        && !(fn_drive_in.oe[PPS_FN_SPI_SEL] && !sel0_reg[5]) |=>
        pin_oe_out.b[5] && pin_out.b[5] == $past(fn_drive_in.out[PPS_FN_TX]))
        else $error("transmit not on alternate pin");
    // default transmit pin back to port
    tx_unsel_a: assert property (sel1_reg[0]
        && !(fn_drive_in.oe[PPS_FN_RX] && sel0_reg[7])
        && !(fn_drive_in.oe[PPS_FN_SPI_DOUT] && !sel0_reg[6]) |=>
        pin_oe_out.b[2] == !$past(dir_b_reg[2]))
        else $error("unselected pin still overridden");
    // upper bits of select 1 read zero
    sel1_read_a: assert property (s_rd(PPS_ADDR_SEL1) |=>
        reg_rdata_out[7:1] == 7'h00)
        else $error("select 1 upper bits nonzero");
    sel_dir_a: assert property (s_wr(PPS_ADDR_SEL0) |=>
        $stable(dir_a_reg) && $stable(dir_b_reg))
        else $error("select write changed direction");

    // Override requests on a chosen pin
    sequence s_spi_out_alt;
        fn_drive_in.oe[PPS_FN_SPI_DOUT] && sel0_reg[6];
    endsequence
    sequence s_cap1_def;
        fn_drive_in.oe[PPS_FN_CAP1] && !sel0_reg[0];
    endsequence
    // spi1 data out reaches pin a6
    spi_out_alt_a: assert property (s_spi_out_alt |=>
        pin_oe_out.a[6] && pin_out.a[6] == $past(fn_drive_in.out[PPS_FN_SPI_DOUT]))
        else $error("spi1 data out not on alternate pin");
    cap1_def_a: assert property (s_cap1_def |=>
        pin_oe_out.b[3] && pin_out.b[3] == $past(fn_drive_in.out[PPS_FN_CAP1]))
        else $error("capture1 not on default pin");
    // spi1 select level from chosen pin
    spi_sel_lvl_a: assert property (1'b1 |=>
        fn_level_out[PPS_FN_SPI_SEL] == $past(sel0_reg[5] ? dig[5] : dig[13]))
        else $error("spi1 select level from wrong pin");
    // pwm2 out b level from chosen pin
    pwm2_b_lvl_a: assert property (1'b1 |=>
        fn_level_out[PPS_FN_PWM2_B] == $past(sel0_reg[4] ? dig[6] : dig[15]))
        else $error("pwm2 out b level from wrong pin");
    cap2_lvl_a: assert property (1'b1 |=>
        fn_level_out[PPS_FN_CAP2] == $past(sel0_reg[3] ? dig[7] : dig[14]))
        else $error("capture2 level from wrong pin");
    // pwm1 out d level from chosen pin
    pwm1_d_lvl_a: assert property (1'b1 |=>
        fn_level_out[PPS_FN_PWM1_D] == $past(sel0_reg[2] ? dig[6] : dig[15]))
        else $error("pwm1 out d level from wrong pin");
    // pwm1 out c level from chosen pin
    pwm1_c_lvl_a: assert property (1'b1 |=>
        fn_level_out[PPS_FN_PWM1_C] == $past(sel0_reg[1] ? dig[7] : dig[14]))
        else $error("pwm1 out c level from wrong pin");
    // pin b4 carries no function, plain port
    drv_pin_b_a: assert property (1'b1 |=>
        pin_oe_out.b[4] == !$past(dir_b_reg[4])
        && pin_out.b[4] == $past(lat_b_reg[4]))
        else $error("pin b4 drive wrong");
    // analog pin a4 still follows direction
    ana_drv_a: assert property (ans_a_reg[4] |=>
        pin_oe_out.a[4] == !$past(dir_a_reg[4]))
        else $error("analog select changed driver");
    // port b level read, analog bits zero
    pin_read_b_a: assert property (s_rd(PPS_ADDR_B_PIN) |=>
        reg_rdata_out == $past(sync2_reg[15:8] & ~ans_b_reg))
        else $error("port b level read mismatch");
    lat_read_b_a: assert property (s_rd(PPS_ADDR_B_LAT) |=>
        reg_rdata_out == $past(lat_b_reg))
        else $error("port b latch read mismatch");
    // port b latch write stores the byte
    lat_write_b_a: assert property (s_wr(PPS_ADDR_B_LAT) |=>
        lat_b_reg == $past(reg_wdata_in))
        else $error("port b latch write lost");
    // select 1 keeps only its low bit
    sel1_keep_a: assert property (s_wr(PPS_ADDR_SEL1) |=>
        sel1_reg[7:1] == 7'h00 && sel1_reg[0] == $past(reg_wdata_in[0]))
        else $error("select 1 write stored wrong bits");
    sel_reset_a: assert property ($rose(nrst_in) |->
        sel0_reg == PPS_RST_SEL && sel1_reg == PPS_RST_SEL)
        else $error("selection not cleared by reset");
endmodule : pps_port

/* dv/pps_pin_model.sv */
// External pin model: resolves design and bench drive on every port pin
`timescale 1ns/1ps
module pps_pin_model
    import pps_pkg::*;
(
    input wire logic core_clk_in,        // System clock
    input wire pps_pins_t pin_drv_in,    // Design drive values
    input wire pps_pins_t pin_en_in,     // Design drive enables
    input wire logic [15:0] ext_val_in,  // Bench drive values
    input wire logic [15:0] ext_en_in,   // Bench drive enables
    output pps_pins_t pin_lvl_out        // Resolved pin levels
);
    logic [15:0] float_reg = 16'h0000; // Level of undriven pins
    logic [15:0] lvl_w; // Resolved levels as a flat vector
    // Undriven pins flip every cycle so a stale level is never read back
    always @(posedge core_clk_in) begin
        float_reg <= ~lvl_w;
    end
    // Design driver wins, then the bench, else the pin floats
    assign lvl_w = (pin_en_in & pin_drv_in) | (~pin_en_in & ext_en_in & ext_val_in)
        | (~pin_en_in & ~ext_en_in & float_reg);
    assign pin_lvl_out = pps_pins_t'(lvl_w);
endmodule : pps_pin_model

/* dv/tb_top.sv */
// Testbench for the port block: register rows, reset, steering and pin cases
`timescale 1ns/1ps
module tb_top;
    import pps_pkg::*;
    logic core_clk_in; // Clock
    logic nrst_in; // Reset, low
    logic [3:0] reg_addr_in; // Bus address
    logic [7:0] reg_wdata_in; // Bus write data
    logic reg_wr_in; // Write strobe
    logic reg_rd_in; // Read strobe
    logic [7:0] reg_rdata_out; // Read data
    pps_pins_t pin_lvl; // Resolved pins
    pps_pins_t pin_out; // Design drive values
    pps_pins_t pin_oe_out; // Design drive enables
    pps_fn_t fn_drive_in; // Peripheral overrides
    logic [8:0] fn_level_out; // Level at function pins
    logic [15:0] ext_val; // Bench pin values
    logic [15:0] ext_en; // Bench pin enables
    int err_total; // Mismatches
    int checked; // Comparisons
    int cyc; // Cycle counter
    int t; // Target pin index
    // Rows: address, write data, expected readback
    logic [19:0] rows [9] = '{20'h0_00_20, 20'h2_ff_df, 20'h3_ff_1f, 20'h4_5a_5a,
        20'h6_a5_a5, 20'h7_3c_3c, 20'h8_c3_c3, 20'h9_ff_01, 20'hc_ff_00};
    // Reset values by address, level registers skipped
    logic [7:0] rst_exp [10] = '{8'hff, 8'h00, 8'h00, 8'h1f, 8'hff, 8'h00, 8'h00,
        8'hff, 8'h00, 8'h00};
    // Default and alternate pin per function, 0-7 port a, 8-15 port b
    int def_pin [9] = '{9, 10, 13, 15, 14, 15, 14, 11, 10};
    int alt_pin [9] = '{10, 6, 5, 6, 7, 6, 7, 8, 13};

    pps_port dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .pin_in(pin_lvl), .pin_out(pin_out),
        .pin_oe_out(pin_oe_out), .fn_drive_in(fn_drive_in), .fn_level_out(fn_level_out));
    pps_pin_model pin_model (.core_clk_in(core_clk_in), .pin_drv_in(pin_out),
        .pin_en_in(pin_oe_out), .ext_val_in(ext_val), .ext_en_in(ext_en),
        .pin_lvl_out(pin_lvl));

    // Clock at 50 MHz
    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    // Read strobe, data taken in the following cycle
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk({8'h00, reg_rdata_out}, {8'h00, e});
    endtask : rchk
    // Let pin changes settle through the synchronizer
    task automatic wait_n(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask : wait_n
    // Verdict and stop
    task automatic end_sim;
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    // Hang guard
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        nrst_in = 1'b0;
        reg_addr_in = 4'h0;
        reg_wdata_in = 8'h00;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        fn_drive_in = '0;
        ext_val = 16'h0000;
        ext_en = 16'hffff;
        err_total = 0;
        checked = 0;
        cyc = 0;
        repeat (2) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        // Ordinary write and readback rows
        foreach (rows[i]) begin
            wr(rows[i][19:16], rows[i][15:8]);
            rchk(rows[i][19:16], rows[i][7:0]);
        end
        // Second reset in mid-run restores every register
        @(posedge core_clk_in);
        nrst_in <= 1'b0;
        @(posedge core_clk_in);
        nrst_in <= 1'b1;
        for (int a = 0; a < 10; a++) begin
            if (a != 1 && a != 5) begin
                rchk(4'(a), rst_exp[a]);
            end
        end
        chk(pin_oe_out, 16'h0000);
        // Steering: each function on each of its pins, all pins inputs
        wr(4'h3, 8'h00);
        wr(4'h7, 8'h00);
        for (int f = 0; f < 9; f++) begin
            for (int s = 0; s < 2; s++) begin
                t = (s != 0) ? alt_pin[f] : def_pin[f];
                wr(f == 8 ? 4'h9 : 4'h8, f == 8 ? 8'(s) : (s != 0 ? 8'h80 >> f : 8'h00));
                fn_drive_in <= {9'h1ff, 9'h001 << f};
                ext_val <= 16'h0001 << t;
                wait_n(6);
                chk({15'h0000, fn_level_out[f]}, 16'h0001);
                chk(pin_oe_out, t == 5 ? 16'h0000 : 16'h0001 << t);
                chk(pin_out & pin_oe_out, t == 5 ? 16'h0000 : 16'h0001 << t);
            end
        end
        fn_drive_in <= '0;
        wr(4'h8, 8'h00);
        wr(4'h9, 8'h00);
        // Three functions share pin b2: lowest index wins
        wr(4'h8, 8'h80);
        fn_drive_in <= {9'h102, 9'h103};
        wait_n(2);
        chk(pin_oe_out.b, 8'h04);
        chk(pin_out.b & 8'h04, 8'h00);
        fn_drive_in <= '0;
        wr(4'h8, 8'h00);
        rchk(4'h0, 8'hff);
        rchk(4'h4, 8'hff);
        // Port a outputs, written through the level register
        ext_val <= 16'h0000;
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h5a);
        wait_n(3);
        chk(pin_oe_out.a, 8'hdf);
        chk(pin_out.a & pin_oe_out.a, 8'h5a);
        rchk(4'h2, 8'h5a);
        rchk(4'h1, 8'h5a);
        // All inputs again: level shows pins, latch keeps its value
        wr(4'h0, 8'hff);
        ext_val <= 16'h00a5;
        wait_n(4);
        rchk(4'h1, 8'ha5);
        rchk(4'h2, 8'h5a);
        // Analog pins driven as outputs: drivers stay on, reads give zero
        ext_val <= 16'h0000;
        wr(4'h0, 8'h00);
        wr(4'h3, 8'h1f);
        wait_n(4);
        chk(pin_oe_out.a, 8'hdf);
        rchk(4'h1, 8'h40);
        // Analog pins kept as inputs, bench drives them high
        wr(4'h0, 8'hff);
        ext_val <= 16'h00ff;
        wait_n(4);
        rchk(4'h1, 8'he0);
        // Port b latch through latch register, upper half analog
        wr(4'h4, 8'h00);
        wr(4'h6, 8'h3c);
        wr(4'h7, 8'hf0);
        wait_n(4);
        chk(pin_out.b, 8'h3c);
        rchk(4'h5, 8'h0c);
        end_sim();
    end
endmodule : tb_top
